//--- core/rfb_pkg.sv
package rfb_pkg;
	localparam int RD_W = 32;
	localparam int SUM_W = 40;
	localparam int MED_WIN_MAX = 11;
	localparam int AVG_DEPTH = 100;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RANK = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_LINE_CYC = 8'h0c;
	localparam logic [7:0] OFS_PRESET = 8'h10;
	localparam logic [7:0] OFS_BASE_AMP = 8'h14;
	localparam logic [7:0] OFS_BASE_OHM = 8'h18;
	localparam logic [7:0] OFS_CAPTURE = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_LAST_OUT = 8'h24;
	// control field positions
	localparam int CB_MED_EN = 0;
	localparam int CB_AVG_EN = 1;
	localparam int CB_AVG_BLOCK = 2;
	localparam int CB_SLOWDOWN = 3;
	localparam int CB_REL_EN = 4;
	localparam int CB_REL_MATH = 5;
	localparam int CB_FUNC_OHM = 6;
	localparam int CB_LINE_50 = 7;
	localparam int CTRL_W = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	// status field positions
	localparam int SB_MED_HELD = 0;
	localparam int SB_AVG_HELD = 8;
	localparam int SB_BUSY = 16;
	// settings limits and resets
	localparam logic [15:0] RANK_MIN = 16'h0001;
	localparam logic [15:0] RANK_MAX = 16'h0005;
	localparam logic [2:0] RANK_RST = 3'h1;
	localparam logic [15:0] COUNT_MIN = 16'h0002;
	localparam logic [15:0] COUNT_MAX = 16'h0064;
	localparam logic [6:0] COUNT_RST = 7'h0a;
	// line cycles kept in hundredths of a cycle
	localparam logic [15:0] PLC_MIN = 16'h0001;
	localparam logic [15:0] PLC_MAX_60 = 16'h1770;
	localparam logic [15:0] PLC_MAX_50 = 16'h1388;
	localparam logic [12:0] PLC_SLOW_60 = 13'h0258;
	localparam logic [12:0] PLC_SLOW_50 = 13'h01f4;
	localparam logic [12:0] PLC_MED = 13'h0064;
	localparam logic [12:0] PLC_FAST = 13'h000a;
	localparam logic [12:0] PLC_RST = 13'h0064;
	localparam logic [1:0] PRESET_SLOW = 2'h0;
	localparam logic [1:0] PRESET_MED = 2'h1;
	localparam logic [1:0] PRESET_FAST = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int LINE_60_NS = 16670000;
	localparam int LINE_50_NS = 20000000;
	localparam int HUND_60_CYC = LINE_60_NS / (CLK_PERIOD_NS * 100);
	localparam int HUND_50_CYC = LINE_50_NS / (CLK_PERIOD_NS * 100);
	localparam logic [5:0] DIV_STEPS = 6'h28;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_DONE = 2'b11
	} rfb_avg_state_t;
endpackage : rfb_pkg

//--- core/rfb_middle_select.sv
`timescale 1ns/1ps
`default_nettype none
module rfb_middle_select
	import rfb_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// control
	input wire logic i_flush,
	input wire logic [2:0] i_rank,
	// reading in
	input wire logic i_valid,
	input wire logic signed [RD_W-1:0] i_data,
	// median out
	output logic o_valid,
	output logic signed [RD_W-1:0] o_data,
	output logic [3:0] o_held
);
	logic signed [RD_W-1:0] win_q [MED_WIN_MAX];
	logic [3:0] held_q;
	logic pend_q;
	logic [3:0] window;
	logic signed [RD_W-1:0] med;

	assign window = {i_rank, 1'b1};
	assign o_held = held_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_valid) begin
			win_q[0] <= i_data;
			for (int k = 1; k < MED_WIN_MAX; k++) begin
				win_q[k] <= win_q[k-1];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || i_flush) begin
			held_q <= 4'h0;
		end else if (i_valid && held_q < window) begin
			held_q <= held_q + 4'h1;
		end
	end

	always_comb begin
		logic [3:0] cnt;
		cnt = 4'h0;
		med = '0;
		for (int i = 0; i < MED_WIN_MAX; i++) begin
			cnt = 4'h0;
			for (int j = 0; j < MED_WIN_MAX; j++) begin
				// ties broken by age so exactly one entry matches
				if (j < held_q && i < held_q && (win_q[j] < win_q[i] ||
						(win_q[j] == win_q[i] && j < i))) begin
					cnt = cnt + 4'h1;
				end
			end
			if (i < held_q && cnt == (held_q >> 1)) begin
				med = win_q[i];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || i_flush) begin
			pend_q <= 1'b0;
			o_valid <= 1'b0;
			o_data <= '0;
		end else begin
			pend_q <= i_valid;
			o_valid <= pend_q;
			if (pend_q) begin
				o_data <= med;
			end
		end
	end
endmodule : rfb_middle_select
`default_nettype wire

//--- core/rfb_reading_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rfb_reading_filter
	import rfb_pkg::*;
#(
	parameter int P_HUND_60_CYC = HUND_60_CYC,
	parameter int P_HUND_50_CYC = HUND_50_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [31:0] o_rdata,
	// converter readings
	input wire logic i_conv_valid,
	input wire logic signed [RD_W-1:0] i_conv_data,
	// math stage output
	input wire logic i_math_valid,
	input wire logic signed [RD_W-1:0] i_math_data,
	// filtered and baseline outputs
	output logic o_smoothing_lamp_valid,
	output logic signed [RD_W-1:0] o_smoothing_lamp_data,
	output logic o_rel_valid,
	output logic signed [RD_W-1:0] o_rel_data,
	// indicators and converter setup
	output logic o_smoothing_lamp,
	output logic o_analog_slowdown_enable,
	output logic [12:0] o_line_cycle_count,
	output logic [31:0] o_integ_cycles
);
	function automatic logic [15:0] clamp16(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : clamp16

	// settings
	logic [CTRL_W-1:0] ctrl_q;
	logic [2:0] rank_q;
	logic [6:0] count_q;
	logic [12:0] line_cyc_q;
	logic signed [RD_W-1:0] base_amp_q;
	logic signed [RD_W-1:0] base_ohm_q;
	logic med_flush_q;
	logic avg_flush_q;
	logic wr_ctrl;
	logic [15:0] plc_max;

	assign wr_ctrl = i_we && i_addr == OFS_CTRL;
	// a control write brings its own line frequency; any other write uses the stored one
	assign plc_max = (wr_ctrl ? i_wdata[CB_LINE_50] : ctrl_q[CB_LINE_50]) ?
		PLC_MAX_50 : PLC_MAX_60;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= i_wdata[CTRL_W-1:0];
		end else if (i_we && (i_addr == OFS_BASE_AMP || i_addr == OFS_BASE_OHM)) begin
			ctrl_q[CB_REL_EN] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rank_q <= RANK_RST;
		end else if (i_we && i_addr == OFS_RANK) begin
			rank_q <= 3'(clamp16(i_wdata[15:0], RANK_MIN, RANK_MAX));
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			count_q <= COUNT_RST;
		end else if (i_we && i_addr == OFS_COUNT) begin
			count_q <= 7'(clamp16(i_wdata[15:0], COUNT_MIN, COUNT_MAX));
		end
	end

	// flush on setting change or disable
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			med_flush_q <= 1'b0;
			avg_flush_q <= 1'b0;
		end else begin
			med_flush_q <= (i_we && i_addr == OFS_RANK) ||
				(wr_ctrl && !i_wdata[CB_MED_EN]);
			avg_flush_q <= (i_we && i_addr == OFS_COUNT) ||
				(wr_ctrl && (!i_wdata[CB_AVG_EN] ||
				i_wdata[CB_AVG_BLOCK] != ctrl_q[CB_AVG_BLOCK]));
		end
	end

	// line cycles clamped per line frequency
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			line_cyc_q <= PLC_RST;
		end else if (i_we && i_addr == OFS_LINE_CYC) begin
			line_cyc_q <= 13'(clamp16(i_wdata[15:0], PLC_MIN, plc_max));
		end else if (wr_ctrl) begin
			// switching to 50 Hz must not leave a count above its ceiling
			line_cyc_q <= 13'(clamp16({3'h0, line_cyc_q}, PLC_MIN, plc_max));
		end else if (i_we && i_addr == OFS_PRESET) begin
			case (i_wdata[1:0])
				PRESET_SLOW: begin
					line_cyc_q <= ctrl_q[CB_LINE_50] ? PLC_SLOW_50 : PLC_SLOW_60;
				end
				PRESET_MED: begin
					line_cyc_q <= PLC_MED;
				end
				PRESET_FAST: begin
					line_cyc_q <= PLC_FAST;
				end
				default: begin
					line_cyc_q <= line_cyc_q;
				end
			endcase
		end
	end

	// period in clocks, all ranges alike
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_integ_cycles <= 32'h0;
			o_line_cycle_count <= 13'h0;
		end else begin
			o_line_cycle_count <= line_cyc_q;
			o_integ_cycles <= 32'({19'h0, line_cyc_q} *
				(ctrl_q[CB_LINE_50] ? 32'(P_HUND_50_CYC) : 32'(P_HUND_60_CYC)));
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_smoothing_lamp <= 1'b0;
			o_analog_slowdown_enable <= 1'b0;
		end else begin
			o_smoothing_lamp <= ctrl_q[CB_MED_EN] || ctrl_q[CB_AVG_EN] ||
				ctrl_q[CB_SLOWDOWN];
			o_analog_slowdown_enable <= ctrl_q[CB_SLOWDOWN];
		end
	end

	// median stage
	logic med_valid;
	logic signed [RD_W-1:0] med_data;
	logic [3:0] med_held;
	logic s1_valid;
	logic signed [RD_W-1:0] s1_data;

	// readings taken only on the converter strobe
	rfb_middle_select u_median (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_flush(med_flush_q),
		.i_rank(rank_q),
		.i_valid(i_conv_valid && ctrl_q[CB_MED_EN]),
		.i_data(i_conv_data),
		.o_valid(med_valid),
		.o_data(med_data),
		.o_held(med_held)
	);

	assign s1_valid = ctrl_q[CB_MED_EN] ? med_valid : i_conv_valid;
	assign s1_data = ctrl_q[CB_MED_EN] ? med_data : i_conv_data;

	// averaging stage
	logic signed [RD_W-1:0] avg_mem [AVG_DEPTH];
	logic [6:0] wr_ptr_q;
	logic [6:0] held_q;
	logic signed [SUM_W-1:0] sum_q;
	logic signed [SUM_W-1:0] sum_d;
	rfb_avg_state_t state_q;
	logic [SUM_W-1:0] dvd_q;
	logic [7:0] rem_q;
	logic [6:0] dvs_q;
	logic neg_q;
	logic [5:0] step_q;
	logic take;
	logic full;
	logic block;
	logic block_done;
	logic [6:0] held_inc;
	logic [7:0] rem_sh;

	assign block = ctrl_q[CB_AVG_BLOCK];
	// readings arriving mid-division are dropped; conversions are far slower
	assign take = s1_valid && ctrl_q[CB_AVG_EN] && state_q == ST_IDLE;
	assign full = held_q == count_q;
	assign held_inc = held_q + 7'h1;
	assign block_done = block && held_inc == count_q;

	always_comb begin
		sum_d = sum_q + SUM_W'(s1_data);
		if (!block && full) begin
			sum_d = sum_d - SUM_W'(avg_mem[wr_ptr_q]);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (take) begin
			avg_mem[wr_ptr_q] <= s1_data;
		end
	end

	// block mode empties after each mean
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || avg_flush_q) begin
			sum_q <= '0;
			held_q <= 7'h0;
			wr_ptr_q <= 7'h0;
		end else if (take) begin
			sum_q <= block_done ? '0 : sum_d;
			held_q <= block_done ? 7'h0 : (full ? held_q : held_inc);
			if (block_done || (!block && held_inc >= count_q && wr_ptr_q + 7'h1 == count_q)) begin
				wr_ptr_q <= 7'h0;
			end else begin
				wr_ptr_q <= wr_ptr_q + 7'h1;
			end
		end
	end

	assign rem_sh = {rem_q[6:0], dvd_q[SUM_W-1]};

	// each sliding take starts a division
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || avg_flush_q) begin
			state_q <= ST_IDLE;
			dvd_q <= '0;
			rem_q <= 8'h0;
			dvs_q <= 7'h1;
			neg_q <= 1'b0;
			step_q <= 6'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// sliding mode does not wait for a full stack; block mode waits for block_done
					if (take && (!block || block_done)) begin
						state_q <= ST_DIV;
						neg_q <= sum_d[SUM_W-1];
						dvd_q <= sum_d[SUM_W-1] ? SUM_W'(-sum_d) : SUM_W'(sum_d);
						rem_q <= 8'h0;
						step_q <= 6'h0;
						// partial stack divides by held count
						dvs_q <= block ? count_q : (full ? held_q : held_inc);
					end
				end
				ST_DIV: begin
					if (rem_sh >= {1'b0, dvs_q}) begin
						rem_q <= rem_sh - {1'b0, dvs_q};
						dvd_q <= {dvd_q[SUM_W-2:0], 1'b1};
					end else begin
						rem_q <= rem_sh;
						dvd_q <= {dvd_q[SUM_W-2:0], 1'b0};
					end
					step_q <= step_q + 6'h1;
					if (step_q == DIV_STEPS - 6'h1) begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// filtered strobe from the averaging stage when enabled, else straight from s1_valid
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_smoothing_lamp_valid <= 1'b0;
			o_smoothing_lamp_data <= '0;
		end else begin
			o_smoothing_lamp_valid <= 1'b0;
			if (ctrl_q[CB_AVG_EN] && state_q == ST_DONE) begin
				o_smoothing_lamp_valid <= 1'b1;
				// quotient fits the reading width; mean never exceeds inputs
				o_smoothing_lamp_data <= neg_q ? -RD_W'(dvd_q) : RD_W'(dvd_q);
			end else if (!ctrl_q[CB_AVG_EN] && s1_valid) begin
				o_smoothing_lamp_valid <= 1'b1;
				o_smoothing_lamp_data <= s1_data;
			end
		end
	end

	// baseline stage
	logic b_valid;
	logic signed [RD_W-1:0] b_data;
	logic signed [RD_W-1:0] base_act;
	logic signed [RD_W-1:0] last_in_q;
	logic wr_cap;

	// raw filtered reading or math stage
	assign b_valid = ctrl_q[CB_REL_MATH] ? i_math_valid : o_smoothing_lamp_valid;
	assign b_data = ctrl_q[CB_REL_MATH] ? i_math_data : o_smoothing_lamp_data;
	assign base_act = ctrl_q[CB_FUNC_OHM] ? base_ohm_q : base_amp_q;
	assign wr_cap = i_we && i_addr == OFS_CAPTURE;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			last_in_q <= '0;
		end else if (b_valid) begin
			last_in_q <= b_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			base_amp_q <= '0;
			base_ohm_q <= '0;
		end else if (i_we && i_addr == OFS_BASE_AMP) begin
			base_amp_q <= i_wdata;
		end else if (i_we && i_addr == OFS_BASE_OHM) begin
			base_ohm_q <= i_wdata;
		end else if (wr_cap && ctrl_q[CB_FUNC_OHM]) begin
			base_ohm_q <= last_in_q;
		end else if (wr_cap) begin
			base_amp_q <= last_in_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rel_valid <= 1'b0;
			o_rel_data <= '0;
		end else begin
			o_rel_valid <= b_valid;
			if (b_valid) begin
				o_rel_data <= ctrl_q[CB_REL_EN] ? b_data - base_act : b_data;
			end
		end
	end

	// register read, one cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_rdata <= 32'h0;
		end else if (i_re) begin
			case (i_addr)
				OFS_CTRL: o_rdata <= 32'(ctrl_q);
				OFS_RANK: o_rdata <= 32'(rank_q);
				OFS_COUNT: o_rdata <= 32'(count_q);
				OFS_LINE_CYC: o_rdata <= 32'(line_cyc_q);
				OFS_BASE_AMP: o_rdata <= base_amp_q;
				OFS_BASE_OHM: o_rdata <= base_ohm_q;
				OFS_STATUS: begin
					o_rdata <= 32'h0;
					o_rdata[SB_MED_HELD +: 4] <= med_held;
					o_rdata[SB_AVG_HELD +: 7] <= held_q;
					o_rdata[SB_BUSY] <= state_q != ST_IDLE;
				end
				OFS_LAST_OUT: o_rdata <= o_rel_data;
				default: o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end
endmodule : rfb_reading_filter
`default_nettype wire

//--- verification/rfb_reading_filter_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rfb_reading_filter_chk
	import rfb_pkg::*;
#(
	parameter int P_HUND_60_CYC = 4,
	parameter int P_HUND_50_CYC = 5
) (
	// watched ports
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [31:0] o_rdata,
	input wire logic i_conv_valid,
	input wire logic i_math_valid,
	input wire logic o_smoothing_lamp_valid,
	input wire logic o_rel_valid,
	input wire logic o_smoothing_lamp,
	input wire logic o_analog_slowdown_enable,
	input wire logic [12:0] o_line_cycle_count,
	input wire logic [31:0] o_integ_cycles
);
	logic [5:0] since_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// cycles since the last reading, saturating
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			since_q <= 6'h3f;
		end else if (i_conv_valid) begin
			since_q <= 6'h00;
		end else if (since_q != 6'h3f) begin
			since_q <= since_q + 6'h01;
		end
	end
	property p_rd_idle;
		!$past(i_re) |-> o_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_smoothing_lamp_cause;
		o_smoothing_lamp_valid |-> since_q <= 6'h37;
	endproperty
	a_smoothing_lamp_cause: assert property (p_smoothing_lamp_cause)
		else $error("filtered strobe without reading");
	property p_rel_cause;
		o_rel_valid |-> $past(o_smoothing_lamp_valid) || $past(i_math_valid);
	endproperty
	a_rel_cause: assert property (p_rel_cause)
		else $error("baseline strobe without source");
	property p_lamp_slow;
		o_analog_slowdown_enable |-> ##[0:1] o_smoothing_lamp;
	endproperty
	a_lamp_slow: assert property (p_lamp_slow)
		else $error("lamp off while slowdown on");
	property p_lamp_chg;
		$changed(o_smoothing_lamp) |-> $past(i_we) || $past(i_we, 2) || $past(i_we, 3);
	endproperty
	a_lamp_chg: assert property (p_lamp_chg)
		else $error("lamp moved without write");
	property p_integ;
		$stable(o_line_cycle_count) [*2] |->
			o_integ_cycles == 32'(o_line_cycle_count) * P_HUND_60_CYC ||
			o_integ_cycles == 32'(o_line_cycle_count) * P_HUND_50_CYC;
	endproperty
	a_integ: assert property (p_integ)
		else $error("integration period wrong");
	property p_plc_range;
		!$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3) |->
			o_line_cycle_count >= 13'h1 && o_line_cycle_count <= 13'h1770;
	endproperty
	a_plc_range: assert property (p_plc_range)
		else $error("line cycles out of range");
	property p_plc_chg;
		$changed(o_line_cycle_count) |-> $past(i_we) || $past(i_we, 2) || $past(i_we, 3)
			|| $past(i_srst) || $past(i_srst, 2) || $past(i_srst, 3);
	endproperty
	a_plc_chg: assert property (p_plc_chg)
		else $error("line cycles moved without write");
endmodule : rfb_reading_filter_chk
bind rfb_reading_filter rfb_reading_filter_chk #(
	.P_HUND_60_CYC(P_HUND_60_CYC),
	.P_HUND_50_CYC(P_HUND_50_CYC)
) u_chk (
	.i_clk_sys(i_clk_sys),
	.i_srst(i_srst),
	.i_we(i_we),
	.i_re(i_re),
	.o_rdata(o_rdata),
	.i_conv_valid(i_conv_valid),
	.i_math_valid(i_math_valid),
	.o_smoothing_lamp_valid(o_smoothing_lamp_valid),
	.o_rel_valid(o_rel_valid),
	.o_smoothing_lamp(o_smoothing_lamp),
	.o_analog_slowdown_enable(o_analog_slowdown_enable),
	.o_line_cycle_count(o_line_cycle_count),
	.o_integ_cycles(o_integ_cycles)
);
`default_nettype wire

//--- verification/rfb_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfb_conv_model
	import rfb_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// requests from the bench
	input wire logic i_go,
	input wire logic i_to_math,
	input wire logic signed [RD_W-1:0] i_value,
	// converter and math stage side
	output logic o_conv_valid,
	output logic signed [RD_W-1:0] o_conv_data,
	output logic o_math_valid,
	output logic signed [RD_W-1:0] o_math_data
);
	// one-cycle strobe; data toggles off the strobe so stale values never match
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_conv_valid <= 1'b0;
			o_math_valid <= 1'b0;
			o_conv_data <= '0;
			o_math_data <= '0;
		end else begin
			o_conv_valid <= i_go & ~i_to_math;
			o_math_valid <= i_go & i_to_math;
			o_conv_data <= (i_go & ~i_to_math) ? i_value : ~o_conv_data;
			o_math_data <= (i_go & i_to_math) ? i_value : ~o_math_data;
		end
	end
endmodule : rfb_conv_model
`default_nettype wire

//--- verification/rfb_reading_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rfb_reading_filter_tb
	import rfb_pkg::*;
;
	logic clk, srst, we, re, go, to_math, cv, mv, fv, rv, lamp, slow;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, integ;
	logic signed [31:0] value, cd, md, fd, rd_q, rel_q;
	logic [12:0] plc;
	int n_mismatch, n_tests;
	always #2 clk = ~clk;
	always @(posedge clk) if (rv === 1'b1) rel_q <= rd_q;
	rfb_conv_model u_conv (.i_clk_sys(clk), .i_srst(srst), .i_go(go), .i_to_math(to_math),
		.i_value(value), .o_conv_valid(cv), .o_conv_data(cd), .o_math_valid(mv),
		.o_math_data(md));
	rfb_reading_filter #(.P_HUND_60_CYC(4), .P_HUND_50_CYC(5)) u_dut (.i_clk_sys(clk),
		.i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
		.i_conv_valid(cv), .i_conv_data(cd), .i_math_valid(mv), .i_math_data(md),
		.o_smoothing_lamp_valid(fv), .o_smoothing_lamp_data(fd), .o_rel_valid(rv), .o_rel_data(rd_q),
		.o_smoothing_lamp(lamp), .o_analog_slowdown_enable(slow), .o_line_cycle_count(plc),
		.o_integ_cycles(integ));
	task test_done;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd
	// one reading in, then wait a bounded time for the filtered strobe
	task conv(input logic [31:0] d, input logic m, input logic w, input logic [31:0] e);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		@(posedge clk);
		value <= d;
		to_math <= m;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (hit !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1 hit = fv;
			n++;
		end
		chk("smoothing_lamp_valid", 32'(w), 32'(hit));
		if (hit === 1'b1) chk("smoothing_lamp_data", e, fd);
		repeat (3) @(posedge clk);
	endtask : conv
	task setc(input logic [7:0] c, input logic [31:0] code, input logic [31:0] e);
		wr(OFS_CTRL, 32'(c));
		if (code != 32'h4) wr(OFS_PRESET, code);
		repeat (3) @(posedge clk);
		#1 chk("plc", e, 32'(plc));
		chk("integ", e * (c[7] ? 32'h5 : 32'h4), integ);
		chk("lamp", 32'(|c[3:0]), 32'(lamp));
		chk("slow", 32'(c[3]), 32'(slow));
	endtask : setc
	initial begin
		clk = 0; srst = 1; addr = 0; wdata = 0; we = 0; re = 0;
		go = 0; to_math = 0; value = 0; n_mismatch = 0; n_tests = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_RANK, 32'h1);
		rd(OFS_COUNT, 32'ha);
		rd(8'h28, 32'h0);
		setc(8'h00, 32'h4, 32'h64);
		wr(OFS_RANK, 32'h9); rd(OFS_RANK, 32'h5);
		wr(OFS_RANK, 32'h0); rd(OFS_RANK, 32'h1);
		wr(OFS_COUNT, 32'h1); rd(OFS_COUNT, 32'h2);
		wr(OFS_COUNT, 32'h65); rd(OFS_COUNT, 32'h64);
		wr(OFS_LINE_CYC, 32'h0); rd(OFS_LINE_CYC, 32'h1);
		wr(OFS_LINE_CYC, 32'h1b58); rd(OFS_LINE_CYC, 32'h1770);
		setc(8'h08, 32'h0, 32'h258);
		setc(8'h01, 32'h1, 32'h64);
		setc(8'h02, 32'h2, 32'ha);
		setc(8'h80, 32'h0, 32'h1f4);
		setc(8'h80, 32'h3, 32'h1f4);
		wr(OFS_LINE_CYC, 32'h1b58); rd(OFS_LINE_CYC, 32'h1388);
		wr(OFS_CTRL, 32'h0); wr(OFS_BASE_AMP, 32'h64); rd(OFS_CTRL, 32'h10);
		conv(250, 0, 1, 250); chk("rel", 150, rel_q);
		rd(OFS_LAST_OUT, 150);
		wr(OFS_BASE_OHM, 32'h7); wr(OFS_CTRL, 32'h50); conv(250, 0, 1, 250);
		chk("rel", 243, rel_q);
		wr(OFS_CTRL, 32'h10); conv(42, 0, 1, 42); wr(OFS_CAPTURE, 32'h0);
		rd(OFS_BASE_AMP, 42); conv(50, 0, 1, 50); chk("rel", 8, rel_q);
		wr(OFS_CTRL, 32'h30); conv(1000, 1, 0, 0); chk("rel", 958, rel_q);
		wr(OFS_BASE_AMP, 32'h80000001); rd(OFS_BASE_AMP, 32'h80000001);
		wr(OFS_CTRL, 32'h1);
		conv(20, 0, 1, 20); conv(1, 0, 1, 20); conv(3, 0, 1, 3);
		conv(4, 0, 1, 3); conv(100, 0, 1, 4);
		wr(OFS_RANK, 32'h2);
		conv(9, 0, 1, 9); conv(-1, 0, 1, 9); conv(8, 0, 1, 8);
		conv(2, 0, 1, 8); conv(7, 0, 1, 7);
		wr(OFS_CTRL, 32'h2); wr(OFS_COUNT, 32'h2);
		conv(10, 0, 1, 10); conv(20, 0, 1, 15);
		conv(40, 0, 1, 30);
		wr(OFS_COUNT, 32'h2); conv(100, 0, 1, 100);
		wr(OFS_CTRL, 32'h6); wr(OFS_COUNT, 32'h3);
		conv(3, 0, 0, 0); conv(6, 0, 0, 0); conv(9, 0, 1, 6); conv(30, 0, 0, 0);
		wr(OFS_RANK, 32'h1); wr(OFS_CTRL, 32'h3); wr(OFS_COUNT, 32'h2);
		conv(20, 0, 1, 20); conv(1, 0, 1, 20); conv(3, 0, 1, 11);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
endmodule : rfb_reading_filter_tb
`default_nettype wire
